// ===== shared/ext_event_if.sv
// Purpose: Carries the recognised external event from the recogniser to the action logic.
// Assumes: Both ends run on the core clock.
// Notes:   The level is the synchronised trigger, offered for status only.
`timescale 1ns/1ns
interface ext_event_if;
  logic event_pulse;
  logic trigger_level;

  modport producer (output event_pulse, output trigger_level);
  modport consumer (input  event_pulse, input  trigger_level);
endinterface

// ===== shared/ext_event_pkg.sv
// Purpose: Shared constants and types for the external debug event action block.
// Assumes: APB register bus with 16-bit byte addresses and 32-bit data.
// Notes:   Every offset, field position, reset value and count lives here.
package ext_event_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] CFG_ADDR        = 16'hfd08;
  localparam logic [15:0] STATUS_ADDR     = 16'hfd40;
  localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITE_MASK  = 32'h0000_00ff;

  // ****************************************************************
  // Configuration register field positions
  // ****************************************************************
  localparam int ACTION_LSB   = 0;
  localparam int ACTION_W     = 3;
  localparam int BBM_BIT      = 3;
  localparam int BOD_BIT      = 4;
  localparam int SUSPEND_OUT_VALUE_BIT     = 5;
  localparam int CNT_LSB      = 6;
  localparam int CNT_W        = 2;

  // ****************************************************************
  // Status register field positions
  // ****************************************************************
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_SUSPEND_OUT_VALUE_BIT = 1;
  localparam int STAT_TRIG_BIT = 2;
  localparam int STAT_CNT_LSB  = 8;
  localparam int EVT_CNT_W     = 8;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam int          BKPT_IRQ_N      = 4;
  localparam logic [3:0]  BKPT_IRQ_IMPL_D = 4'h3;
  localparam logic [1:0]  CNT_KEEP        = 2'h0;
  localparam logic [1:0]  CNT_START       = 2'h1;
  localparam logic [1:0]  CNT_STOP        = 2'h2;
  localparam logic [1:0]  CNT_TOGGLE      = 2'h3;
  localparam logic [2:0]  ACT_DISABLED    = 3'h0;
  localparam logic [2:0]  ACT_PULSE_ONLY  = 3'h1;
  localparam logic [2:0]  ACT_HALT        = 3'h2;
  localparam logic [2:0]  ACT_TRAP        = 3'h3;

  // Decoded effects of one event.
  typedef struct packed {
    logic       pulse;
    logic       halt;
    logic       trap;
    logic [3:0] irq;
  } action_type;

endpackage

// ===== src/ext_event_action.sv
// Purpose: Configuration register and action logic for the external debug event.
// Assumes: APB slave on the core clock; the trigger pin is asynchronous to it.
// Notes:   Action outputs are one-cycle pulses; suspend and counter run are levels.
//
// Operation
// - On an event the counter action field 01 starts and 10 stops the task-mode performance counters, 00 keeps them.
// - On an event the counter action field 11 toggles the performance counter run control.
// - On an event the suspend-out signal takes the value of the suspend-out value bit.
// - With break-out disable at 0 the break-out signal pulses as the action code dictates.
// - With break-out disable at 1 the break-out signal never pulses for this event.
// - The break ordering bit selects break after make at 0 and break before make at 1.
// - With break-out enabled, codes 000 to 011 mean nothing, pulse only, halt plus pulse, trap plus pulse.
// - With break-out enabled, code 100 raises breakpoint interrupt 0 with a break-out pulse.
// - With break-out enabled, codes 101 to 111 raise breakpoint interrupt 1 to 3 with a pulse where provided.
// - A code that selects a breakpoint interrupt not provided gives no break-out pulse, halt, trap or interrupt.
// - With break-out disabled, codes mean disabled, none, halt, trap and interrupts 0 to 3 without pulse.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module ext_event_action
  import ext_event_pkg::*;
#(
  parameter logic [3:0] BKPT_IRQ_IMPL = BKPT_IRQ_IMPL_D
)(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              ext_trigger_i,
  output logic                   break_out_signal_o,
  output logic                   halt_req_o,
  output logic                   bkpt_trap_o,
  output logic      [3:0]        bkpt_irq_o,
  output logic                   suspend_out_o,
  output logic                   perf_run_o,
  output logic                   break_before_make_o
);

  // Each event spends one cycle in each phase; a new event is only taken in the idle phase.
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SECOND
  } phase_type;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // True when the address names a register of this block.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // Turns a code and the break-out disable bit into the effects of one event.
  function automatic action_type decode_action(input logic [2:0] code,
                                               input logic       breakout_disable,
                                               input logic [3:0] impl);
    action_type a;
    logic [1:0] idx;
    a   = '0;
    idx = code[1:0];
    // Codes with the top bit set select a breakpoint interrupt line by their low bits.
    if (code[2]) begin
      if (impl[idx]) begin
        a.irq[idx] = 1'b1;
        a.pulse    = 1'b1;
      end
    end else begin
      case (code)
        ACT_PULSE_ONLY: a.pulse = 1'b1;
        ACT_HALT: begin
          a.halt  = 1'b1;
          a.pulse = 1'b1;
        end
        ACT_TRAP: begin
          a.trap  = 1'b1;
          a.pulse = 1'b1;
        end
        default: a = '0;
      endcase
    end
    // Break-out disable wins over every code, so it is applied last.
    if (breakout_disable) begin
      a.pulse = 1'b0;
    end
    decode_action = a;
  endfunction

  // ****************************************************************
  // Event recogniser
  // ****************************************************************

  ext_event_if evt_bus ();

  ext_event_detect u_detect (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .trigger_i (ext_trigger_i),
    .evt       (evt_bus.producer)
  );

  // ****************************************************************
  // Register bus
  // ****************************************************************

  logic [31:0]          cfg_q;
  logic [31:0]          cfg_d;
  logic [31:0]          prdata_q;
  logic [31:0]          prdata_d;
  logic                 pready_q;
  logic                 pready_d;
  logic                 pslverr_q;
  logic                 pslverr_d;
  logic                 setup_phase;
  logic                 wr_commit;
  logic                 hit_cfg;
  logic                 hit_stat;
  logic [EVT_CNT_W-1:0] evt_cnt_q;
  logic [EVT_CNT_W-1:0] evt_cnt_d;

  // Zero wait states: ready rises in the access cycle that follows every setup cycle.
  assign setup_phase = psel_i & ~penable_i;
  assign wr_commit   = psel_i & penable_i & pready_q & pwrite_i;
  assign hit_cfg     = addr_hit(paddr_i, CFG_ADDR);
  assign hit_stat    = addr_hit(paddr_i, STATUS_ADDR);

  // Answer is prepared in the setup cycle so ready and data come from flip-flops.
  always_comb begin
    pready_d  = setup_phase;
    pslverr_d = setup_phase & ~hit_cfg & ~hit_stat;
    prdata_d  = 32'h0000_0000;
    if (setup_phase && !pwrite_i) begin
      if (hit_cfg) begin
        prdata_d = cfg_q & CFG_WRITE_MASK;
      end else if (hit_stat) begin
        // Status is read only; the trigger level helps to spot a pin that is stuck high.
        prdata_d[STAT_RUN_BIT]                         = perf_run_o;
        prdata_d[STAT_TRIG_BIT]                        = evt_bus.trigger_level;
        prdata_d[STAT_SUSPEND_OUT_VALUE_BIT]                        = suspend_out_o;
        prdata_d[STAT_CNT_LSB +: EVT_CNT_W]            = evt_cnt_q;
      end
    end
  end

  // Software writes land only at the completing access edge; status is read only.
  always_comb begin
    cfg_d = cfg_q;
    if (wr_commit && hit_cfg) begin
      cfg_d = pwdata_i & CFG_WRITE_MASK;
    end
  end

  // Bus answer and configuration registers.
  // Ready, error and read data are registered so the bus sees them settle from flip-flops.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q     <= CFG_RESET;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************************************
  // Event actions
  // ****************************************************************

  logic       run_q;
  logic       run_d;
  logic       suspend_out_value_q;
  logic       suspend_out_value_d;
  logic       brk_q;
  logic       brk_d;
  logic       halt_q;
  logic       halt_d;
  logic       trap_q;
  logic       trap_d;
  logic [3:0] irq_q;
  logic [3:0] irq_d;
  logic       bbm_q;
  logic       bbm_d;
  phase_type  phase_q;
  phase_type  phase_d;
  action_type pend_q;
  action_type pend_d;
  action_type now_act;
  logic       fire;

  // The configuration is sampled at the event, so a later write cannot split one event.
  // A limitation: an event that arrives in the second phase is lost, so triggers need gaps.
  assign now_act = decode_action(cfg_q[ACTION_LSB +: ACTION_W], cfg_q[BOD_BIT], BKPT_IRQ_IMPL);
  assign fire    = evt_bus.event_pulse & (phase_q == ST_IDLE);

  // Counter run control and suspend level follow each event.
  always_comb begin
    run_d     = run_q;
    suspend_out_value_d    = suspend_out_value_q;
    evt_cnt_d = evt_cnt_q;
    bbm_d     = cfg_q[BBM_BIT];
    if (fire) begin
      suspend_out_value_d    = cfg_q[SUSPEND_OUT_VALUE_BIT];
      // The event count wraps; software compares two reads to see how many events passed.
      evt_cnt_d = evt_cnt_q + 8'h01;
      // Toggle reads the current run state, so two toggling events cancel.
      case (cfg_q[CNT_LSB +: CNT_W])
        CNT_START:  run_d = 1'b1;
        CNT_STOP:   run_d = 1'b0;
        CNT_TOGGLE: run_d = ~run_q;
        default:    run_d = run_q;
      endcase
    end
  end

  // Two-phase ordering: one cycle carries the break, the next the make, or the other way round.
  always_comb begin
    brk_d   = 1'b0;
    halt_d  = 1'b0;
    trap_d  = 1'b0;
    irq_d   = 4'h0;
    pend_d  = '0;
    phase_d = ST_IDLE;
    case (phase_q)
      ST_IDLE: begin
        if (fire) begin
          pend_d  = now_act;
          phase_d = ST_SECOND;
          if (cfg_q[BBM_BIT]) begin
            brk_d = now_act.pulse;
          end else begin
            halt_d = now_act.halt;
            trap_d = now_act.trap;
            irq_d  = now_act.irq;
          end
        end
      end
      ST_SECOND: begin
        // The second phase replays whatever the first phase held back.
        if (bbm_q) begin
          halt_d = pend_q.halt;
          trap_d = pend_q.trap;
          irq_d  = pend_q.irq;
        end else begin
          brk_d = pend_q.pulse;
        end
      end
      default: phase_d = ST_IDLE;
    endcase
  end

  // Event action registers.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q     <= 1'b0;
      suspend_out_value_q    <= 1'b0;
      evt_cnt_q <= '0;
      bbm_q     <= 1'b0;
      brk_q     <= 1'b0;
      halt_q    <= 1'b0;
      trap_q    <= 1'b0;
      irq_q     <= 4'h0;
      pend_q    <= '0;
      phase_q   <= ST_IDLE;
    end else begin
      run_q     <= run_d;
      suspend_out_value_q    <= suspend_out_value_d;
      evt_cnt_q <= evt_cnt_d;
      bbm_q     <= bbm_d;
      brk_q     <= brk_d;
      halt_q    <= halt_d;
      trap_q    <= trap_d;
      irq_q     <= irq_d;
      pend_q    <= pend_d;
      phase_q   <= phase_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every output comes straight from a register, so downstream logic sees no glitches.
  assign prdata_o            = prdata_q;
  assign pready_o            = pready_q;
  assign pslverr_o           = pslverr_q;
  assign break_out_signal_o  = brk_q;
  assign halt_req_o          = halt_q;
  assign bkpt_trap_o         = trap_q;
  assign bkpt_irq_o          = irq_q;
  assign suspend_out_o       = suspend_out_value_q;
  assign perf_run_o          = run_q;
  assign break_before_make_o = bbm_q;

endmodule

// ===== src/ext_event_detect.sv
// Purpose: Synchronises the external trigger pin and turns each assertion into one event pulse.
// Assumes: The trigger is asynchronous to clock_i and stays low at least two cycles between events.
// Notes:   Only the second synchroniser stage and later are read by logic.
`timescale 1ns/1ns
module ext_event_detect
  import ext_event_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     rst_n_i,
  input  wire logic     trigger_i,
  ext_event_if.producer evt
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic pulse_q;
  logic sync1_d;
  logic sync2_d;
  logic prev_d;
  logic pulse_d;

  // ****************************************************************
  // Synchroniser and rising edge detector
  // ****************************************************************

  // A rising edge of the synchronised level is one event, so a held trigger fires once.
  always_comb begin
    sync1_d = trigger_i;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    pulse_d = sync2_q & ~prev_q;
  end

  // Registers of the synchroniser and the event pulse.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
      pulse_q <= pulse_d;
    end
  end

  assign evt.event_pulse   = pulse_q;
  assign evt.trigger_level = prev_q;

endmodule

// ===== tb/ext_event_action_checker.sv
// Purpose: Port-level checks of the external event action block.
// Assumes: Configuration is not rewritten while an event is in flight.
// Notes:   The configuration word is shadowed from completed APB writes.
`timescale 1ns/1ns
module ext_event_action_checker
  import ext_event_pkg::*;
#(
  parameter logic [3:0] BKPT_IRQ_IMPL = BKPT_IRQ_IMPL_D
)(
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              ext_trigger_i,
  input wire logic              break_out_signal_o,
  input wire logic              halt_req_o,
  input wire logic              bkpt_trap_o,
  input wire logic [3:0]        bkpt_irq_o,
  input wire logic              suspend_out_o,
  input wire logic              perf_run_o,
  input wire logic              break_before_make_o
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic       act;

  // The shadow follows each write that completes on the configuration word.
  always_comb begin
    cfg_d = cfg_q;
    if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == CFG_ADDR) begin
      cfg_d = pwdata_i[7:0];
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  assign act = halt_req_o || bkpt_trap_o || (bkpt_irq_o != 4'h0);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  a_error_unmapped: assert property (pslverr_o |-> pready_o && paddr_i != CFG_ADDR && paddr_i != STATUS_ADDR)
    else $error("error on a mapped word");
  a_bo_disabled: assert property (break_out_signal_o |-> !cfg_q[BOD_BIT]) else $error("break out while disabled");
  a_bbm_copy: assert property (break_before_make_o == $past(cfg_q[BBM_BIT])) else $error("order level wrong");
  a_break_first: assert property (act && cfg_q[BBM_BIT] && !cfg_q[BOD_BIT] |-> $past(break_out_signal_o))
    else $error("break did not lead");
  a_make_first: assert property (act && !cfg_q[BBM_BIT] && !cfg_q[BOD_BIT] |=> break_out_signal_o)
    else $error("break did not follow");
  a_one_action: assert property ($onehot0({halt_req_o, bkpt_trap_o, bkpt_irq_o})) else $error("two actions");
  a_halt_code: assert property (halt_req_o |-> cfg_q[2:0] == ACT_HALT) else $error("halt on wrong code");
  a_trap_code: assert property (bkpt_trap_o |-> cfg_q[2:0] == ACT_TRAP) else $error("trap on wrong code");
  a_irq_code: assert property (bkpt_irq_o != 4'h0 |-> cfg_q[2] && bkpt_irq_o == (4'h1 << cfg_q[1:0]))
    else $error("wrong interrupt line");
  a_irq_impl: assert property ((bkpt_irq_o & ~BKPT_IRQ_IMPL) == 4'h0) else $error("missing line raised");
  a_single_pulse: assert property ($rose(break_out_signal_o) |=> !break_out_signal_o) else $error("long pulse");
  a_read_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside ready");
  a_suspend_out_value_value: assert property ($changed(suspend_out_o) |-> suspend_out_o == cfg_q[SUSPEND_OUT_VALUE_BIT])
    else $error("suspend level wrong");
  a_run_change: assert property ($changed(perf_run_o) |-> cfg_q[CNT_LSB +: CNT_W] != CNT_KEEP)
    else $error("counter run moved");
  a_out_after_trig: assert property (break_out_signal_o || act |-> $past(ext_trigger_i, 4) || $past(ext_trigger_i, 5))
    else $error("action without trigger");
endmodule

bind ext_event_action ext_event_action_checker #(.BKPT_IRQ_IMPL(BKPT_IRQ_IMPL)) i_ext_event_action_checker (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ext_trigger_i(ext_trigger_i), .break_out_signal_o(break_out_signal_o), .halt_req_o(halt_req_o),
  .bkpt_trap_o(bkpt_trap_o), .bkpt_irq_o(bkpt_irq_o), .suspend_out_o(suspend_out_o),
  .perf_run_o(perf_run_o), .break_before_make_o(break_before_make_o));

// ===== tb/ext_event_action_tb.sv
// Purpose: Self-checking bench for the external event action block.
// Assumes: Default interrupt lines; zero-wait APB slave.
// Notes:   Every action code is fired with break-out both enabled and disabled.
`timescale 1ns/1ns
module ext_event_action_tb
  import ext_event_pkg::*;
;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, trig;
  logic        bo, halt, trap, suspend_out_value, run, break_before_make_select, err, exp_run;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  irq;
  int          num_errors, check_count, cycles;

  ext_event_action i_ext_event_action (.clock_i(clock), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ext_trigger_i(trig), .break_out_signal_o(bo), .halt_req_o(halt),
    .bkpt_trap_o(trap), .bkpt_irq_o(irq), .suspend_out_o(suspend_out_value), .perf_run_o(run),
    .break_before_make_o(break_before_make_select));
  ext_trigger_src i_ext_trigger_src (.clock_i(clock), .trigger_o(trig));

  task automatic test_done();
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request is held until ready is seen high, for at most 20 cycles.
  task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0, "no ready");
  endtask

  // Configure, fire one event and watch the action outputs around it.
  task automatic event_check(input logic [7:0] cfg, input int high);
    int         c_bo, c_act, n_bo, n_act;
    logic [3:0] irq_or, irq_exp;
    logic       h, t, ok, pul;
    logic [2:0] code;
    {c_bo, c_act, n_bo, n_act} = '0;
    {irq_or, h, t} = '0;
    code = cfg[2:0];
    apb(1'b1, CFG_ADDR, {24'h0, cfg});
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, {24'h0, cfg}, "readback");
    fork
      i_ext_trigger_src.fire(high);
      for (int c = 0; c < 14; c++) begin
        @(negedge clock);
        if (bo === 1'b1) begin
          n_bo++;
          c_bo = c;
        end
        if (halt === 1'b1 || trap === 1'b1 || irq !== 4'h0) begin
          n_act++;
          c_act = c;
        end
        h |= halt;
        t |= trap;
        irq_or |= irq;
      end
    join
    ok = code >= ACT_HALT && (!code[2] || BKPT_IRQ_IMPL_D[code[1:0]]);
    pul = !cfg[BOD_BIT] && (code == ACT_PULSE_ONLY || ok);
    irq_exp = (code[2] && BKPT_IRQ_IMPL_D[code[1:0]]) ? 4'h1 << code[1:0] : 4'h0;
    case (cfg[7:6])
      CNT_START: exp_run = 1'b1;
      CNT_STOP: exp_run = 1'b0;
      CNT_TOGGLE: exp_run = !exp_run;
      default: exp_run = exp_run;
    endcase
    chk(32'(n_bo), {31'h0, pul}, "break out");
    chk({26'h0, h, t, irq_or}, {26'h0, code == ACT_HALT, code == ACT_TRAP, irq_exp}, "action");
    chk(32'(n_act), {31'h0, ok}, "action count");
    chk({31'h0, suspend_out_value}, {31'h0, cfg[SUSPEND_OUT_VALUE_BIT]}, "suspend");
    chk({31'h0, run}, {31'h0, exp_run}, "counter run");
    chk({31'h0, break_before_make_select}, {31'h0, cfg[BBM_BIT]}, "order level");
    if (pul && ok) chk(32'(c_act - c_bo), cfg[BBM_BIT] ? 32'h1 : 32'hffff_ffff, "order");
  endtask

  // Free-running clock at 50 MHz.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      test_done();
    end
  end

  // Register checks first, then each action code with both break-out settings.
  initial begin
    {rst_n, psel, penable, pwrite, exp_run} = '0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, CFG_RESET, "reset value");
    apb(1'b1, CFG_ADDR, 32'hffff_ff00);
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, 32'h0, "reserved bits");
    apb(1'b0, 16'hfd0c, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped word");
    for (int i = 0; i < 16; i++) begin
      event_check({2'(i * 3), i[2] ^ i[0], i[3], i[1] ^ i[0], 3'(i)}, 1 + 2 * i[0]);
    end
    apb(1'b1, STATUS_ADDR, 32'hffff_ffff);
    chk({31'h0, err}, 32'h0, "status write error");
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, {16'h0, 8'h10, 5'h0, 1'b0, 1'b0, exp_run}, "status");
    test_done();
  end
endmodule

// ===== tb/ext_trigger_src.sv
// Purpose: External debug trigger source standing beside the event action block.
// Assumes: The bench calls fire once per wanted event.
// Notes:   The pin idles low and stays low three cycles after each event.
`timescale 1ns/1ns
module ext_trigger_src (
  input  wire logic clock_i,
  output logic      trigger_o
);
  initial trigger_o = 1'b0;

  // A long high level must still count as one event, so the width varies.
  task automatic fire(input int high_cycles);
    @(posedge clock_i);
    trigger_o <= 1'b1;
    repeat (high_cycles) @(posedge clock_i);
    trigger_o <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask
endmodule
